// >>> include/dsco_pkg.sv
package dsco_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_COMMAND    = 8'h00;
  localparam logic [7:0] OFF_SECTOR     = 8'h04;
  localparam logic [7:0] OFF_TRACK_SECS = 8'h08;
  localparam logic [7:0] OFF_STATUS     = 8'h0C;
  localparam logic [7:0] OFF_LENGTH     = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT   = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN     = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLR    = 8'h1C;

  // ****************************************
  // Command layout
  // ****************************************
  localparam int        CMD_TYPE_HI   = 7;
  localparam int        CMD_TYPE_LO   = 5;
  localparam int        CMD_MULTI_BIT = 4;
  localparam int        CMD_BLEN_BIT  = 3;
  localparam logic [2:0] TYPE_READ    = 3'h4;
  localparam logic [2:0] TYPE_WRITE   = 3'h5;
  localparam logic [3:0] TYPE_FORCE   = 4'hD;

  // ****************************************
  // Status and interrupt bits
  // ****************************************
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_CRC_BIT   = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_CRC_BIT  = 1;
  localparam int IRQ_FORCE_BIT = 2;
  localparam int IRQ_W        = 3;

  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int          LEN_MULT       = 16;
  localparam int          LEN_SHIFT      = 4;
  localparam logic [7:0]  RST_SECTOR     = 8'h01;
  localparam logic [7:0]  RST_TRACK_SECS = 8'h1A;

  typedef enum logic [2:0]
  {
    DSCO_IDLE = 3'b001,
    DSCO_XFER = 3'b010,
    DSCO_DONE = 3'b100
  } dsco_state_t;
endpackage : dsco_pkg

// >>> design/dsco_len_calc.sv
`timescale 1ns/10ps
// Sector data size from the on-disk length code
module dsco_len_calc
  import dsco_pkg::*;
(
  input  wire logic [7:0]  len_code,
  input  wire logic        std_block,
  output logic      [11:0] byte_count
);
  import dsco_pkg::*;

  always_comb
  begin
    // Standard sizing is outside this block; keep the same rule
    if (!std_block)
      byte_count = {len_code, 4'h0};
    else
      byte_count = {len_code, 4'h0};
  end
endmodule : dsco_len_calc

// >>> design/dsco_rec_ctr.sv
`timescale 1ns/10ps
// Record counter: advances sector, flags end of track
module dsco_rec_ctr
  import dsco_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic       advance,
  input  wire logic [7:0] track_secs,
  output logic      [7:0] sector,
  output logic            past_end
);
  import dsco_pkg::*;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      sector <= RST_SECTOR;
    else if (load)
      sector <= load_val;
    else if (advance)
      sector <= sector + 8'h01;
  end

  assign past_end = (sector > track_secs);
endmodule : dsco_rec_ctr

// >>> design/dsco_cmd_opts.sv
`timescale 1ns/10ps
// Contract
// - Single record: one sector, then interrupt
// - Multi record: advance sector after each
// - Stop and interrupt past track end
// - Forced interrupt ends transfer, raises interrupt
// - Non-standard size is length code times 16
// - Data CRC error ends command, sets status
module dsco_cmd_opts
  import dsco_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rec_done,
  input  wire logic        rec_crc_err,
  input  wire logic [7:0]  rec_len_code,
  output logic             data_request,
  output logic             xfer_write,
  output logic      [7:0]  xfer_sector,
  output logic      [11:0] xfer_bytes,
  output logic             irq
);
  import dsco_pkg::*;

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0]       command;
  logic [7:0]       track_secs;
  logic [7:0]       status;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [11:0]      length;
  dsco_state_t      state;
  logic             multi;
  logic             blen;
  logic             wr_cmd;
  logic [7:0]       sector;
  logic             past_end;
  logic [11:0]      calc_bytes;

  logic wr_acc;
  logic rd_acc;
  logic cmd_wr;
  logic sec_wr;
  logic is_xfer_cmd;
  logic is_force;
  logic ev_done;
  logic ev_crc;
  logic ev_force;
  logic advance;
  logic adv_d;
  logic track_end;

  function automatic logic known_addr(input logic [7:0] a);
    case (a)
      OFF_COMMAND, OFF_SECTOR, OFF_TRACK_SECS, OFF_STATUS,
      OFF_LENGTH, OFF_IRQ_STAT, OFF_IRQ_EN, OFF_IRQ_CLR:
        known_addr = 1'b1;
      default:
        known_addr = 1'b0;
    endcase
  endfunction : known_addr

  // ****************************************
  // APB slave, zero wait states
  // ****************************************
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !known_addr(paddr);
  assign wr_acc  = psel && penable && pwrite && known_addr(paddr);
  // Loaded in setup so read data already stands at the access edge
  assign rd_acc  = psel && !penable && !pwrite;
  assign cmd_wr  = wr_acc && (paddr == OFF_COMMAND);
  assign sec_wr  = wr_acc && (paddr == OFF_SECTOR) && (state == DSCO_IDLE);

  assign is_xfer_cmd = (pwdata[CMD_TYPE_HI:CMD_TYPE_LO] == TYPE_READ)
                    || (pwdata[CMD_TYPE_HI:CMD_TYPE_LO] == TYPE_WRITE);
  assign is_force    = (pwdata[CMD_TYPE_HI:CMD_TYPE_HI-3] == TYPE_FORCE);

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      prdata <= 32'h0000_0000;
    else if (rd_acc)
    begin
      case (paddr)
        OFF_COMMAND:    prdata <= {24'h0, command};
        OFF_SECTOR:     prdata <= {24'h0, sector};
        OFF_TRACK_SECS: prdata <= {24'h0, track_secs};
        OFF_STATUS:     prdata <= {24'h0, status};
        OFF_LENGTH:     prdata <= {20'h0, length};
        OFF_IRQ_STAT:   prdata <= {29'h0, irq_stat};
        OFF_IRQ_EN:     prdata <= {29'h0, irq_en};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      track_secs <= RST_TRACK_SECS;
    else if (wr_acc && (paddr == OFF_TRACK_SECS))
      track_secs <= pwdata[7:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      irq_en <= '0;
    else if (wr_acc && (paddr == OFF_IRQ_EN))
      irq_en <= pwdata[IRQ_W-1:0];
  end

  // ****************************************
  // Command sequencer
  // ****************************************
  assign ev_crc   = (state == DSCO_XFER) && rec_done && rec_crc_err;
  assign ev_force = (state == DSCO_XFER) && cmd_wr && is_force;
  assign advance  = (state == DSCO_XFER) && rec_done && !rec_crc_err
                    && multi && !ev_force;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state   <= DSCO_IDLE;
      command <= 8'h00;
      multi   <= 1'b0;
      blen    <= 1'b0;
      wr_cmd  <= 1'b0;
    end
    else
    begin
      case (state)
        DSCO_IDLE:
        begin
          if (cmd_wr && is_xfer_cmd)
          begin
            command <= pwdata[7:0];
            multi   <= pwdata[CMD_MULTI_BIT];
            blen    <= pwdata[CMD_BLEN_BIT];
            wr_cmd  <= pwdata[CMD_TYPE_LO];
            state   <= DSCO_XFER;
          end
        end
        DSCO_XFER:
        begin
          if (ev_force)
          begin
            command <= pwdata[7:0];
            state   <= DSCO_DONE;
          end
          else if (ev_crc)
            state <= DSCO_DONE;
          else if (rec_done && !multi)
            state <= DSCO_DONE;
          else if (track_end)
            state <= DSCO_DONE;
        end
        DSCO_DONE:
          state <= DSCO_IDLE;
        default:
          state <= DSCO_IDLE;
      endcase
    end
  end

  // Past-end check uses the advanced sector, one cycle after advance
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      adv_d <= 1'b0;
    else
      adv_d <= advance;
  end

  // ev_done fires once per single-record or track end; CRC and forced ends raise only their own bits
  assign track_end = (state == DSCO_XFER) && adv_d && past_end
                     && !ev_force && !ev_crc;
  assign ev_done   = ((state == DSCO_XFER) && rec_done && !multi
                     && !rec_crc_err && !ev_force)
                   || track_end;

  // Track end handled on its own since it leaves the sequencer above
  logic term_track;
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      term_track <= 1'b0;
    else
      term_track <= track_end;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      status <= 8'h00;
    else
    begin
      status[ST_BUSY_BIT] <= (state == DSCO_XFER) && !term_track
                             && !track_end;
      if (cmd_wr && is_xfer_cmd && (state == DSCO_IDLE))
        status[ST_CRC_BIT] <= 1'b0;
      else if (ev_crc)
        status[ST_CRC_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      length <= 12'h000;
    else if ((state == DSCO_XFER) && rec_done)
      length <= calc_bytes;
  end

  // ****************************************
  // Interrupt status, set wins over clear
  // ****************************************
  logic [IRQ_W-1:0] ev_vec;
  logic [IRQ_W-1:0] clr_vec;
  assign ev_vec  = {ev_force, ev_crc, ev_done};
  assign clr_vec = (wr_acc && (paddr == OFF_IRQ_CLR)) ?
                   pwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      irq_stat <= '0;
    else
      irq_stat <= (irq_stat & ~clr_vec) | ev_vec;
  end

  assign irq = |(irq_stat & irq_en);

  // ****************************************
  // Record-side outputs
  // ****************************************
  logic xfer_live;
  assign xfer_live = (state == DSCO_XFER) && !track_end && !term_track;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      data_request <= 1'b0;
      xfer_write   <= 1'b0;
      xfer_sector  <= RST_SECTOR;
      xfer_bytes   <= 12'h000;
    end
    else
    begin
      data_request <= xfer_live && !rec_done && !advance;
      xfer_write   <= wr_cmd;
      xfer_sector  <= sector;
      xfer_bytes   <= calc_bytes;
    end
  end

  // Sector counter and size rule
  dsco_rec_ctr u_rec_ctr
  (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .load       (sec_wr),
    .load_val   (pwdata[7:0]),
    .advance    (advance),
    .track_secs (track_secs),
    .sector     (sector),
    .past_end   (past_end)
  );

  dsco_len_calc u_len_calc
  (
    .len_code   (rec_len_code),
    .std_block  (blen),
    .byte_count (calc_bytes)
  );
endmodule : dsco_cmd_opts

// >>> bench/dsco_cmd_opts_assertions.sv
`timescale 1ns/10ps
module dsco_cmd_opts_assertions
  import dsco_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rec_done,
  input wire logic        rec_crc_err,
  input wire logic [7:0]  rec_len_code,
  input wire logic        data_request,
  input wire logic [7:0]  xfer_sector,
  input wire logic [11:0] xfer_bytes
);
  logic       wr;
  logic       rec;
  logic       multi_q;
  logic [7:0] track_q;
  assign wr = psel && penable && pwrite;
  assign rec = rec_done && data_request;
  // Track size as software last set it
  always_ff @(posedge core_clk)
    if (!rst_b)
      track_q <= RST_TRACK_SECS;
    else if (wr && paddr == OFF_TRACK_SECS)
      track_q <= pwdata[7:0];
  always_ff @(posedge core_clk)
    if (!rst_b)
      multi_q <= 1'b0;
    else if (wr && paddr == OFF_COMMAND && pwdata[7:6] == 2'h2)
      multi_q <= pwdata[CMD_MULTI_BIT];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  chk_bad_addr: assert property (psel && penable && (paddr > OFF_IRQ_CLR
    || paddr[1:0] != 2'h0) |-> pslverr) else $error("no pslverr");
  chk_single_stop: assert property (rec && !multi_q |-> ##[1:2] !data_request)
    else $error("single record did not end");
  chk_multi_step: assert property (rec && multi_q && !rec_crc_err |=> ##1
    xfer_sector == $past(xfer_sector) + 8'h01) else $error("no advance");
  chk_multi_keep: assert property (rec && multi_q && !rec_crc_err
    && xfer_sector < track_q |=> ##1 data_request[*2])
    else $error("early end");
  chk_track_end: assert property (rec && multi_q && !rec_crc_err
    && xfer_sector >= track_q |-> ##[1:3] !data_request)
    else $error("no end at track end");
  chk_force_stop: assert property (wr && paddr == OFF_COMMAND && data_request
    && pwdata[7:4] == TYPE_FORCE |-> ##[1:2] !data_request)
    else $error("force did not end");
  chk_crc_stop: assert property (rec && rec_crc_err |-> ##[1:2] !data_request)
    else $error("crc did not end");
  chk_len_x16: assert property (rec |-> ##[0:2]
    xfer_bytes == {rec_len_code, 4'h0}) else $error("bad size");
  cov_multi: cover property (rec && multi_q);
  cov_crc: cover property (rec && rec_crc_err);
  cov_err: cover property (pslverr);
endmodule : dsco_cmd_opts_assertions

// >>> bench/dsco_rec_model.sv
`timescale 1ns/10ps
// Disk side: one record after every gap cycles with data_request high; data_request low restarts the count
module dsco_rec_model
(
  input  wire logic       core_clk,
  input  wire logic       data_request,
  input  wire logic       crc_on,
  input  wire logic [7:0] len_in,
  input  wire logic [7:0] gap,
  output logic            rec_done,
  output logic            rec_crc_err,
  output logic      [7:0] rec_len_code,
  output int              n_rec
);
  int cnt;
  initial
  begin
    rec_done = 1'b0;
    rec_crc_err = 1'b0;
    rec_len_code = 8'h00;
    n_rec = 0;
    cnt = 0;
    forever
    begin
      @(posedge core_clk);
      rec_done <= 1'b0;
      // Meaningless outside a pulse, so keep it moving
      rec_crc_err <= ~rec_crc_err;
      rec_len_code <= len_in;
      cnt = (data_request === 1'b1) ? cnt + 1 : 0;
      if (cnt >= gap)
      begin
        cnt = 0;
        n_rec++;
        rec_done <= 1'b1;
        rec_crc_err <= crc_on;
      end
    end
  end
endmodule : dsco_rec_model

// >>> bench/tb_dsco_cmd_opts.sv
`timescale 1ns/10ps
module tb_dsco_cmd_opts;
  import dsco_pkg::*;
  logic        core_clk, rst_b, psel, penable, pwrite, crc_on, err;
  logic        pready, pslverr, rec_done, rec_crc_err, data_request;
  logic        xfer_write, irq;
  logic [7:0]  paddr, len_in, gap, rec_len_code, xfer_sector;
  logic [11:0] xfer_bytes;
  logic [31:0] pwdata, prdata, rd;
  logic [27:0] rows [4];
  int          mismatches, check_count, n_rec, n0;
  dsco_cmd_opts i_dsco_cmd_opts (.core_clk, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rec_done,
    .rec_crc_err, .rec_len_code, .data_request, .xfer_write, .xfer_sector,
    .xfer_bytes, .irq);
  dsco_rec_model i_dsco_rec_model (.core_clk, .data_request, .crc_on,
    .len_in, .gap, .rec_done, .rec_crc_err, .rec_len_code, .n_rec);
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic check(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", s, e, g);
    end
  endtask : check
  task automatic run(input logic [7:0] c, input logic [7:0] s);
    int lo;
    lo = 0;
    apb(1'b1, OFF_SECTOR, {24'h0, s});
    n0 = n_rec;
    apb(1'b1, OFF_COMMAND, {24'h0, c});
    for (int i = 0; i < 20 && data_request !== 1'b1; i++)
      @(posedge core_clk);
    // Multi records dip for one cycle between records
    for (int i = 0; i < 400 && lo < 3; i++)
    begin
      @(posedge core_clk);
      lo = (data_request === 1'b0) ? lo + 1 : 0;
    end
    repeat (2) @(posedge core_clk);
  endtask : run
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial
  begin
    #150000;
    mismatches++;
    results();
  end
  initial
  begin
    {rst_b, psel, penable, pwrite, crc_on, paddr, pwdata} = '0;
    len_in = 8'h01;
    gap = 8'h03;
    rows = '{{8'h80, 8'h01, 12'h010}, {8'hA0, 8'h02, 12'h020},
             {8'h84, 8'h03, 12'h030}, {8'hA4, 8'h04, 12'h040}};
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    #1 check("sector", 8'h01, xfer_sector);
    check("irq", 1'b0, irq);
    apb(1'b0, OFF_TRACK_SECS, 32'h0);
    check("track", {24'h0, RST_TRACK_SECS}, rd);
    apb(1'b0, 8'h20, 32'h0);
    check("pslverr", 1'b1, err);
    apb(1'b1, OFF_IRQ_EN, 32'h7);
    $display("reset test done");
    foreach (rows[i])
    begin
      len_in = rows[i][19:12];
      run(rows[i][27:20], 8'h05);
      check("records", 1, n_rec - n0);
      check("bytes", rows[i][11:0], xfer_bytes);
      check("write", rows[i][25], xfer_write);
      check("irq", 1'b1, irq);
      apb(1'b1, OFF_IRQ_CLR, 32'h7);
      @(posedge core_clk);
      check("irq clr", 1'b0, irq);
    end
    $display("row test done");
    gap = 8'h09;
    apb(1'b1, OFF_TRACK_SECS, 32'h3);
    run(8'h90, 8'h02);
    check("records", 2, n_rec - n0);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    check("done", 32'h1, rd);
    apb(1'b1, OFF_IRQ_CLR, 32'h7);
    apb(1'b1, OFF_TRACK_SECS, 32'h1A);
    apb(1'b1, OFF_SECTOR, 32'h1);
    n0 = n_rec;
    apb(1'b1, OFF_COMMAND, 32'hB0);
    while (n_rec < n0 + 3) @(posedge core_clk);
    apb(1'b1, OFF_COMMAND, 32'hD0);
    repeat (3) @(posedge core_clk);
    check("force end", 1'b0, data_request);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    check("force", 1'b1, rd[IRQ_FORCE_BIT]);
    apb(1'b1, OFF_IRQ_CLR, 32'h7);
    $display("multi test done");
    crc_on = 1'b1;
    run(8'h90, 8'h01);
    check("records", 1, n_rec - n0);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("crc status", 1'b1, rd[ST_CRC_BIT]);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    check("crc irq", 1'b1, rd[IRQ_CRC_BIT]);
    apb(1'b1, OFF_IRQ_CLR, 32'h7);
    crc_on = 1'b0;
    apb(1'b1, OFF_IRQ_EN, 32'h0);
    run(8'h80, 8'h01);
    check("masked", 1'b0, irq);
    apb(1'b1, OFF_IRQ_EN, 32'h1);
    #1 check("unmasked", 1'b1, irq);
    $display("crc and mask test done");
    results();
  end
endmodule : tb_dsco_cmd_opts
bind dsco_cmd_opts dsco_cmd_opts_assertions i_dsco_cmd_opts_assertions (
  .core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .rec_done, .rec_crc_err, .rec_len_code, .data_request,
  .xfer_sector, .xfer_bytes);
